// *** tb_trs_routing_unit.sv ***
`timescale 1ns/1ps
module tb_trs_routing_unit;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [63:0] pat = 64'h0000_0000_0000_0000;
	logic [63:0] src;
	logic [31:0] q;
	logic e;
	logic [1:0] pf;
	logic [3:0] sel = 4'hf;
	wire [31:0] rdat;
	wire ack, er, refd, rsvd;
	wire [2:0] lock;
	wire [11:0] rt;
	int failures = 0;
	int num_checks = 0;
	always #10 clk_i = ~clk_i;
	trs_src_model src_m (.clk_i(clk_i), .pat_i(pat), .trig_src_o(src));
	trs_routing_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(er), .trig_src_i(src),
		.timer19_break_in0_o(rt[0]), .timer19_break_in1_o(rt[1]),
		.timer19_break_in2_o(rt[2]), .timer19_break_in3_o(rt[3]),
		.timer20_internal_trig0_o(rt[4]), .timer20_internal_trig1_o(rt[5]),
		.timer20_internal_trig2_o(rt[6]), .timer20_internal_trig3_o(rt[7]),
		.timer20_break_in0_o(rt[8]), .timer20_break_in1_o(rt[9]),
		.timer20_break_in2_o(rt[10]), .timer20_break_in3_o(rt[11]),
		.write_lock_flag_o(lock), .write_refused_o(refd),
		.reserved_write_o(rsvd));
	task automatic complete_run();
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, x);
		num_checks++;
		if (s !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d,
		input logic [3:0] s = trs_pkg::TRS_SEL_FULL);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		// answer sampled at rising edges only
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && er !== 1'b1 && n < 50);
		if (ack !== 1'b1 && er !== 1'b1) begin
			failures++;
			complete_run();
		end else begin
			q = rdat;
			e = er;
			cyc <= 1'b0;
			// status pulses stand in the cycle after the answer
			@(posedge clk_i);
			pf = {refd, rsvd};
		end
	endtask
	task automatic route(input logic [63:0] p, input logic [11:0] x);
		pat <= p;
		repeat (3) @(negedge clk_i);
		chk("route", {20'h0_0000, rt}, {20'h0_0000, x});
		@(posedge clk_i);
	endtask
	initial begin
		do_reset();
		bus(1'b0, 8'h28, 32'h0000_0000);
		chk("r28", q, 32'h3939_3939);
		bus(1'b0, 8'h2c, 32'h0000_0000);
		chk("r2c", q, 32'h1515_1515);
		// partial-lane write: acked, but the register keeps its value
		bus(1'b1, 8'h2c, 32'h0101_0101, 4'h3);
		bus(1'b0, 8'h2c, 32'h0000_0000);
		chk("r2cp", q, 32'h1515_1515);
		bus(1'b0, 8'h30, 32'h0000_0000);
		chk("r30", q, 32'h0000_0000);
		chk("lock", {29'h0, lock}, 32'h0000_0000);
		bus(1'b0, 8'h34, 32'h0000_0000);
		chk("err", {31'h0, e}, 32'h0000_0001);
		route(64'h0200_0000_0020_0001, 12'hfff);
		bus(1'b1, 8'h28, 32'h0403_0201);
		bus(1'b1, 8'h2c, 32'h4040_4040);
		// bit 23 set on purpose: must be dropped
		bus(1'b1, 8'h30, 32'h3fbf_3f3f);
		chk("rsv", {30'h0, pf}, 32'h0000_0001);
		bus(1'b0, 8'h30, 32'h0000_0000);
		chk("r30w", q, 32'h3f3f_3f3f);
		for (int i = 0; i < 4; i++)
			route(64'h8000_0000_0000_0002 << i | 64'h8000_0000_0000_0000,
				12'hf01 << i | 12'hf00);
		route(64'hffff_ffff_ffff_ffff, 12'hf0f);
		bus(1'b1, 8'h28, 32'h8506_0708);
		chk("lock1", {29'h0, lock}, 32'h0000_0001);
		bus(1'b1, 8'h28, 32'h0000_0000);
		chk("refd", {30'h0, pf}, 32'h0000_0002);
		bus(1'b0, 8'h28, 32'h0000_0000);
		chk("r28l", q, 32'h8506_0708);
		route(64'h0000_0000_0000_0100, 12'h001);
		do_reset();
		bus(1'b0, 8'h28, 32'h0000_0000);
		chk("r28r", q, 32'h3939_3939);
		chk("lock0", {29'h0, lock}, 32'h0000_0000);
		complete_run();
	end
endmodule

// *** trs_chk_sva.sv ***
`timescale 1ns/1ps
module trs_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [63:0] trig_src_i,
	input wire logic timer19_break_in0_o,
	input wire logic timer20_internal_trig3_o,
	input wire logic [2:0] write_lock_flag_o,
	input wire logic write_refused_o
);
	logic [2:0] dirty_r;
	logic wr;
	logic rd;
	assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i == 4'hf;
	assign rd = wb_ack_o && wb_cyc_i && !wb_we_i;
	// registers touched since reset no longer hold reset codes
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dirty_r <= 3'h0;
		else if (wr)
			dirty_r <= dirty_r | {wb_adr_i == 8'h30, wb_adr_i == 8'h2c,
				wb_adr_i == 8'h28};
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	lock_sticky_a: assert property ((write_lock_flag_o &
		$past(write_lock_flag_o)) == $past(write_lock_flag_o))
		else $error("lock bit cleared");
	lock_set_a: assert property (wr && wb_adr_i == 8'h28 && wb_dat_i[31]
		|=> write_lock_flag_o[0]) else $error("lock not set");
	refuse_cause_a: assert property (write_refused_o |-> $past(wr) &&
		|$past(write_lock_flag_o)) else $error("refusal without lock");
	reset_t19_a: assert property (rd && wb_adr_i == 8'h28 && !dirty_r[0]
		|-> wb_dat_o == 32'h3939_3939) else $error("bad reset 28");
	reset_t20t_a: assert property (rd && wb_adr_i == 8'h2c && !dirty_r[1]
		|-> wb_dat_o == 32'h1515_1515) else $error("bad reset 2c");
	reset_t20b_a: assert property (rd && wb_adr_i == 8'h30 && !dirty_r[2]
		|-> wb_dat_o == 32'h0000_0000) else $error("bad reset 30");
	route_out0_a: assert property (!dirty_r[0] && !$past(rst_i)
		|-> timer19_break_in0_o == $past(trig_src_i[57]))
		else $error("out0 misrouted");
	route_out3_a: assert property (!dirty_r[1] && !$past(rst_i)
		|-> timer20_internal_trig3_o == $past(trig_src_i[21]))
		else $error("out3 misrouted");
endmodule
bind trs_routing_unit trs_chk u_chk (.*);

// *** trs_pkg.sv ***
package trs_pkg;

	// bus geometry
	localparam int TRS_ADR_W = 8;
	localparam int TRS_DAT_W = 32;
	localparam int TRS_SEL_W = 4;
	localparam logic [3:0] TRS_SEL_FULL = 4'hf;

	// register offsets (byte addresses)
	localparam logic [7:0] TRS_OFF_T19_BRK = 8'h28;
	localparam logic [7:0] TRS_OFF_T20_TRG = 8'h2c;
	localparam logic [7:0] TRS_OFF_T20_BRK = 8'h30;

	// register index inside the bank
	localparam int TRS_NUM_REGS = 3;
	localparam logic [1:0] TRS_IDX_T19_BRK = 2'h0;
	localparam logic [1:0] TRS_IDX_T20_TRG = 2'h1;
	localparam logic [1:0] TRS_IDX_T20_BRK = 2'h2;

	// reset values
	localparam logic [31:0] TRS_RST_T19_BRK = 32'h3939_3939;
	localparam logic [31:0] TRS_RST_T20_TRG = 32'h1515_1515;
	localparam logic [31:0] TRS_RST_T20_BRK = 32'h0000_0000;

	// field layout
	localparam int TRS_LOCK_BIT = 31;
	localparam int TRS_NUM_FIELDS = 4;
	localparam int TRS_CODE_W = 7;
	localparam int TRS_FIELD_STRIDE = 8;
	localparam logic [31:0] TRS_RSVD_MASK = 32'h0080_8080;

	// internal trigger sources; codes at or above this count are unassigned
	localparam int TRS_NUM_SRC = 64;
	localparam int TRS_SRC_IDX_W = 6;
	localparam logic [6:0] TRS_CODE_LIMIT = 7'h40;

	function automatic logic [6:0] trs_field(input logic [31:0] w,
		input int idx);
		return w[idx * TRS_FIELD_STRIDE +: TRS_CODE_W];
	endfunction

	function automatic logic [31:0] trs_pack(input logic lock,
		input logic [3:0][6:0] code);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int f = 0; f < TRS_NUM_FIELDS; f++) begin
			w[f * TRS_FIELD_STRIDE +: TRS_CODE_W] = code[f];
		end
		w[TRS_LOCK_BIT] = lock;
		return w;
	endfunction

	function automatic logic [3:0][6:0] trs_unpack(input logic [31:0] w);
		logic [3:0][6:0] c;
		for (int f = 0; f < TRS_NUM_FIELDS; f++) begin
			c[f] = trs_field(w, f);
		end
		return c;
	endfunction

endpackage

// *** trs_routing_unit.sv ***
`timescale 1ns/1ps
module trs_routing_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [trs_pkg::TRS_ADR_W-1:0] wb_adr_i,
	input wire logic [trs_pkg::TRS_SEL_W-1:0] wb_sel_i,
	input wire logic [trs_pkg::TRS_DAT_W-1:0] wb_dat_i,
	output logic [trs_pkg::TRS_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [trs_pkg::TRS_NUM_SRC-1:0] trig_src_i,
	output logic timer19_break_in0_o,
	output logic timer19_break_in1_o,
	output logic timer19_break_in2_o,
	output logic timer19_break_in3_o,
	output logic timer20_internal_trig0_o,
	output logic timer20_internal_trig1_o,
	output logic timer20_internal_trig2_o,
	output logic timer20_internal_trig3_o,
	output logic timer20_break_in0_o,
	output logic timer20_break_in1_o,
	output logic timer20_break_in2_o,
	output logic timer20_break_in3_o,
	output logic [2:0] write_lock_flag_o,
	output logic write_refused_o,
	output logic reserved_write_o
);

	typedef enum logic [1:0] {
		TRS_IDLE = 2'b01,
		TRS_ANS = 2'b10
	} trs_bus_t;

	typedef struct packed {
		trs_bus_t bus;
		logic [2:0] lock;
		logic [2:0][3:0][6:0] code;
		logic [1:0] idx;
		logic hit;
		logic [31:0] rdat;
		logic ack;
		logic err;
		logic refused;
		logic rsvd;
	} trs_state_t;

	trs_state_t st_r;
	trs_state_t st_nxt;

	logic req;
	logic dec_hit;
	logic [1:0] dec_idx;
	logic wr_go;
	logic [2:0][3:0] route_w;

	assign req = wb_cyc_i & wb_stb_i;

	// address decode, only aligned word offsets hit
	always_comb begin
		dec_hit = 1'b1;
		dec_idx = trs_pkg::TRS_IDX_T19_BRK;
		unique case (wb_adr_i)
			trs_pkg::TRS_OFF_T19_BRK: begin
				dec_idx = trs_pkg::TRS_IDX_T19_BRK;
			end
			trs_pkg::TRS_OFF_T20_TRG: begin
				dec_idx = trs_pkg::TRS_IDX_T20_TRG;
			end
			trs_pkg::TRS_OFF_T20_BRK: begin
				dec_idx = trs_pkg::TRS_IDX_T20_BRK;
			end
			default: begin
				dec_hit = 1'b0;
			end
		endcase
	end

	// write commits on the edge where the master samples ack
	assign wr_go = (st_r.bus == TRS_ANS) & st_r.ack & st_r.hit & req
		& wb_we_i & (wb_sel_i == trs_pkg::TRS_SEL_FULL);

	always_comb begin
		st_nxt = st_r;
		st_nxt.refused = 1'b0;
		st_nxt.rsvd = 1'b0;
		unique case (st_r.bus)
			TRS_IDLE: begin
				st_nxt.ack = 1'b0;
				st_nxt.err = 1'b0;
				if (req) begin
					st_nxt.bus = TRS_ANS;
					st_nxt.hit = dec_hit;
					st_nxt.idx = dec_idx;
					st_nxt.ack = dec_hit;
					st_nxt.err = ~dec_hit;
					st_nxt.rdat = 32'h0000_0000;
					if (dec_hit) begin
						// reserved bits read back as zero
						st_nxt.rdat = trs_pkg::trs_pack(st_r.lock[dec_idx],
							st_r.code[dec_idx]);
					end
				end
			end
			TRS_ANS: begin
				st_nxt.bus = TRS_IDLE;
				st_nxt.ack = 1'b0;
				st_nxt.err = 1'b0;
				if (wr_go) begin
					if (st_r.lock[st_r.idx]) begin
						// whole word dropped while locked
						st_nxt.refused = 1'b1;
					end else begin
						st_nxt.code[st_r.idx] =
							trs_pkg::trs_unpack(wb_dat_i);
						// sticky: a write of 0 never clears it
						st_nxt.lock[st_r.idx] = st_r.lock[st_r.idx]
							| wb_dat_i[trs_pkg::TRS_LOCK_BIT];
						// flag software breaking the reserved-zero contract
						st_nxt.rsvd = |(wb_dat_i
							& trs_pkg::TRS_RSVD_MASK);
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r.bus <= TRS_IDLE;
			st_r.lock[trs_pkg::TRS_IDX_T19_BRK] <=
				trs_pkg::TRS_RST_T19_BRK[trs_pkg::TRS_LOCK_BIT];
			st_r.lock[trs_pkg::TRS_IDX_T20_TRG] <=
				trs_pkg::TRS_RST_T20_TRG[trs_pkg::TRS_LOCK_BIT];
			st_r.lock[trs_pkg::TRS_IDX_T20_BRK] <=
				trs_pkg::TRS_RST_T20_BRK[trs_pkg::TRS_LOCK_BIT];
			st_r.code[trs_pkg::TRS_IDX_T19_BRK] <=
				trs_pkg::trs_unpack(trs_pkg::TRS_RST_T19_BRK);
			st_r.code[trs_pkg::TRS_IDX_T20_TRG] <=
				trs_pkg::trs_unpack(trs_pkg::TRS_RST_T20_TRG);
			st_r.code[trs_pkg::TRS_IDX_T20_BRK] <=
				trs_pkg::trs_unpack(trs_pkg::TRS_RST_T20_BRK);
			st_r.idx <= 2'h0;
			st_r.hit <= 1'b0;
			st_r.rdat <= 32'h0000_0000;
			st_r.ack <= 1'b0;
			st_r.err <= 1'b0;
			st_r.refused <= 1'b0;
			st_r.rsvd <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// one selector per output, registered
	for (genvar r = 0; r < trs_pkg::TRS_NUM_REGS; r++) begin : g_reg
		for (genvar f = 0; f < trs_pkg::TRS_NUM_FIELDS; f++) begin : g_fld
			trs_src_mux u_mux (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.code_i(st_r.code[r][f]),
				.src_i(trig_src_i),
				.out_o(route_w[r][f])
			);
		end
	end

	assign timer19_break_in0_o = route_w[0][0];
	assign timer19_break_in1_o = route_w[0][1];
	assign timer19_break_in2_o = route_w[0][2];
	assign timer19_break_in3_o = route_w[0][3];
	assign timer20_internal_trig0_o = route_w[1][0];
	assign timer20_internal_trig1_o = route_w[1][1];
	assign timer20_internal_trig2_o = route_w[1][2];
	assign timer20_internal_trig3_o = route_w[1][3];
	assign timer20_break_in0_o = route_w[2][0];
	assign timer20_break_in1_o = route_w[2][1];
	assign timer20_break_in2_o = route_w[2][2];
	assign timer20_break_in3_o = route_w[2][3];

	assign wb_dat_o = st_r.rdat;
	assign wb_ack_o = st_r.ack;
	assign wb_err_o = st_r.err;
	assign write_lock_flag_o = st_r.lock;
	assign write_refused_o = st_r.refused;
	assign reserved_write_o = st_r.rsvd;

endmodule

// *** trs_src_model.sv ***
`timescale 1ns/1ps
module trs_src_model (
	input wire logic clk_i,
	input wire logic [63:0] pat_i,
	output logic [63:0] trig_src_o
);
	// sources move just after an edge, as clocked logic would
	always_ff @(posedge clk_i) begin
		trig_src_o <= pat_i;
	end
endmodule

// *** trs_src_mux.sv ***
`timescale 1ns/1ps
module trs_src_mux (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [6:0] code_i,
	input wire logic [trs_pkg::TRS_NUM_SRC-1:0] src_i,
	output logic out_o
);

	typedef struct packed {
		logic out;
	} trs_mux_state_t;

	trs_mux_state_t st_r;
	trs_mux_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// unassigned codes drive the output low
		if (code_i < trs_pkg::TRS_CODE_LIMIT) begin
			st_nxt.out = src_i[code_i[trs_pkg::TRS_SRC_IDX_W-1:0]];
		end else begin
			st_nxt.out = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_o = st_r.out;

endmodule
